/* hdl/clk_activity_monitor.sv */
// Pixel clock activity monitor: pixel-domain toggle counted per core window
`default_nettype none
module clk_activity_monitor (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_pixel_clock_input,
	input wire logic i_monitor_enable,
	output logic o_active
);
	import pwr_mode_pkg::*;

	logic prst_s1_r;
	logic prst_s2_r;
	logic ptog_r;
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;
	logic [9:0] win_r;
	logic [9:0] win_nxt;
	logic [7:0] edges_r;
	logic [7:0] edges_nxt;
	logic active_r;
	logic active_nxt;
	logic pix_edge;
	logic win_end;

	// Reset reaches the pixel domain through two flops
	always_ff @(posedge i_pixel_clock_input) begin
		prst_s1_r <= i_rst_n;
		prst_s2_r <= prst_s1_r;
	end

	// One toggle per pixel period; a stopped clock freezes it
	// Held clear until the synchronised release is seen high, so a clock
	// that first runs after reset still starts the toggle from a known level
	always_ff @(posedge i_pixel_clock_input) begin
		if (prst_s2_r) begin
			ptog_r <= ~ptog_r;
		end else begin
			ptog_r <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end else begin
			tog_s1_r <= ptog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end

	assign pix_edge = tog_s2_r ^ tog_s3_r;
	assign win_end = (win_r == MON_WIN_CYC - 10'h001);
	assign win_nxt = (win_end || !i_monitor_enable) ? 10'h000 :
		win_r + 10'h001;
	assign edges_nxt = (win_end || !i_monitor_enable) ? 8'h00 :
		(pix_edge && edges_r != 8'hff) ? edges_r + 8'h01 : edges_r;
	// Hysteresis between the two limits keeps the mode from chattering
	assign active_nxt = !i_monitor_enable ? MON_RESET_ACTIVE :
		!win_end ? active_r :
		(edges_r >= MON_ACT_EDGES) ? 1'b1 :
		(edges_r < MON_IDLE_EDGES) ? 1'b0 : active_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			win_r <= 10'h000;
			edges_r <= 8'h00;
			active_r <= MON_RESET_ACTIVE;
		end else begin
			win_r <= win_nxt;
			edges_r <= edges_nxt;
			active_r <= active_nxt;
		end
	end

	assign o_active = active_r;
endmodule
`default_nettype wire

/* hdl/enable_qualifier.sv */
// Stability timer that qualifies the synchronised transmitter enable level
`default_nettype none
module enable_qualifier (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_level,
	output logic o_qualified
);
	import pwr_mode_pkg::*;

	logic [10:0] count_r;
	logic [10:0] count_nxt;
	logic qual_r;
	logic qual_nxt;
	logic differs;
	logic [10:0] limit;
	logic expired;

	// Rise needs the enable-high time, fall needs the power-down time
	assign limit = qual_r ? PWRDN_CYC : EN_QUAL_CYC;
	assign differs = i_level ^ qual_r;
	// Any glitch back to the old level restarts the interval
	assign expired = differs && (count_r == limit);
	assign count_nxt = (!differs || expired) ? 11'h000 : count_r + 11'h001;
	assign qual_nxt = expired ? i_level : qual_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			count_r <= 11'h000;
			qual_r <= QUAL_RESET_LEVEL;
		end else begin
			count_r <= count_nxt;
			qual_r <= qual_nxt;
		end
	end

	assign o_qualified = qual_r;
endmodule
`default_nettype wire

/* hdl/serializer_power_mode_control.sv */
// Operating-mode sequencer of the camera serial-link converter
//
// Behaviour
// - Enable low over 10 us: shutdown, PLL and serializer off, outputs off.
// - Enable high, no pixel clock: standby, only monitor runs, outputs off.
// - Enable high and clock active: acquire, PLL on, outputs still off.
// - In acquire with line-count option high, start frame line counter.
// - Enable high and PLL locked: transmit, serializing parallel data.
// - Enable high over 10 us leaves shutdown into standby, monitor on.
// - Entering transmit: latch shift register, init counter, clock, data.
// - Transmit entry waits for the PLL lock indication.
// - Pixel clock lost in transmit: standby, outputs off, PLL off.
// - Enable low past power-down time: clock off, data off, then shutdown.
// - Input stages stay sensing even in shutdown.
// - Monitor: below 500 kHz inactive, above 3 MHz active.
// - After lock wait one frame-sync rise, two with option high.
`default_nettype none
module serializer_power_mode_control (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_pixel_clock_input,
	input wire logic i_transmitter_enable_pin,
	input wire logic i_line_count_option,
	input wire logic i_frame_sync,
	input wire logic i_pll_locked,
	output logic o_monitor_enable,
	output logic o_pll_enable,
	output logic o_serializer_enable,
	output logic o_shift_load,
	output logic o_line_counter_run,
	output logic o_line_counter_init,
	output logic o_clk_out_oe,
	output logic o_data_out_oe,
	output logic [1:0] o_mode
);
	import pwr_mode_pkg::*;

	// Pin synchronisers; first stages feed only the second stages
	logic en_s1_r;
	logic en_s2_r;
	logic opt_s1_r;
	logic opt_s2_r;
	logic fs_s1_r;
	logic fs_s2_r;
	logic fs_s3_r;
	logic lock_s1_r;
	logic lock_s2_r;

	mode_state_e state_r;
	mode_state_e state_nxt;
	logic [1:0] sync_cnt_r;
	logic [1:0] sync_cnt_nxt;

	logic monitor_enable_r;
	logic pll_enable_r;
	logic serializer_enable_r;
	logic shift_load_r;
	logic line_counter_run_r;
	logic line_counter_init_r;
	logic clk_out_oe_r;
	logic data_out_oe_r;
	logic [1:0] mode_r;

	logic enable_q;
	logic clk_active;
	logic fs_rise;
	logic [1:0] sync_need;
	logic sync_done;
	logic in_entry;
	logic monitor_enable_nxt;
	logic pll_enable_nxt;
	logic serializer_enable_nxt;
	logic shift_load_nxt;
	logic line_counter_run_nxt;
	logic line_counter_init_nxt;
	logic clk_out_oe_nxt;
	logic data_out_oe_nxt;
	logic [1:0] mode_nxt;

	// One-hot view of the next state, then the overlapping group decodes (locking, entry, serial)
	logic go_shutdown;
	logic go_standby;
	logic go_acquire;
	logic go_wait_sync;
	logic go_latch;
	logic go_line_init;
	logic go_clk_on;
	logic go_transmit;
	logic go_pd_clk_off;
	logic go_pd_data_off;
	logic go_locking;
	logic go_entry;
	logic go_serial;

	// Synchronisers run in every state so a rising enable is seen
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end else begin
			en_s1_r <= i_transmitter_enable_pin;
			en_s2_r <= en_s1_r;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			opt_s1_r <= 1'b0;
			opt_s2_r <= 1'b0;
		end else begin
			opt_s1_r <= i_line_count_option;
			opt_s2_r <= opt_s1_r;
		end
	end

	// Third stage is the edge detector; idle low matches its reset value
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			fs_s1_r <= 1'b0;
			fs_s2_r <= 1'b0;
			fs_s3_r <= 1'b0;
		end else begin
			fs_s1_r <= i_frame_sync;
			fs_s2_r <= fs_s1_r;
			fs_s3_r <= fs_s2_r;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			lock_s1_r <= 1'b0;
			lock_s2_r <= 1'b0;
		end else begin
			lock_s1_r <= i_pll_locked;
			lock_s2_r <= lock_s1_r;
		end
	end

	// A glitchy enable never reaches the sequencer unqualified
	enable_qualifier u_enable_qualifier (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_level(en_s2_r),
		.o_qualified(enable_q)
	);

	// Monitor powered in every state except shutdown
	clk_activity_monitor u_clk_activity_monitor (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_pixel_clock_input(i_pixel_clock_input),
		.i_monitor_enable(monitor_enable_r),
		.o_active(clk_active)
	);

	assign fs_rise = fs_s2_r && !fs_s3_r;
	assign sync_need = opt_s2_r ? SYNC_EDGES_COUNT_ON :
		SYNC_EDGES_COUNT_OFF;
	assign sync_done = fs_rise && (sync_cnt_r + 2'h1 >= sync_need);
	assign in_entry = (state_r == ST_LATCH) ||
		(state_r == ST_LINE_INIT) || (state_r == ST_CLK_ON);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_SHUTDOWN: begin
				if (enable_q) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (!enable_q) begin
					// Outputs already off; skipping the steps keeps the PLL off
					state_nxt = ST_SHUTDOWN;
				end else if (clk_active) begin
					state_nxt = ST_ACQUIRE;
				end
			end
			ST_ACQUIRE: begin
				if (!enable_q) begin
					state_nxt = ST_SHUTDOWN;
				end else if (!clk_active) begin
					state_nxt = ST_STANDBY;
				end else if (lock_s2_r) begin
					state_nxt = ST_WAIT_SYNC;
				end
			end
			ST_WAIT_SYNC: begin
				if (!enable_q) begin
					state_nxt = ST_SHUTDOWN;
				end else if (!clk_active || !lock_s2_r) begin
					state_nxt = clk_active ? ST_ACQUIRE : ST_STANDBY;
				end else if (sync_done) begin
					state_nxt = ST_LATCH;
				end
			end
			ST_LATCH: begin
				state_nxt = ST_LINE_INIT;
			end
			ST_LINE_INIT: begin
				state_nxt = ST_CLK_ON;
			end
			ST_CLK_ON: begin
				state_nxt = ST_TRANSMIT;
			end
			ST_TRANSMIT: begin
				if (!enable_q) begin
					state_nxt = ST_PD_CLK_OFF;
				end else if (!clk_active) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_PD_CLK_OFF: begin
				state_nxt = ST_PD_DATA_OFF;
			end
			ST_PD_DATA_OFF: begin
				state_nxt = ST_SHUTDOWN;
			end
			default: begin
				state_nxt = ST_SHUTDOWN;
			end
		endcase
		// Short entry sequence is aborted by loss of enable or clock
		if (in_entry && (!enable_q || !clk_active)) begin
			state_nxt = enable_q ? ST_STANDBY : ST_SHUTDOWN;
		end
	end

	assign sync_cnt_nxt = (state_r != ST_WAIT_SYNC) ? 2'h0 :
		fs_rise ? sync_cnt_r + 2'h1 : sync_cnt_r;

	// Next-state decode shared by every output flop
	assign go_shutdown = (state_nxt == ST_SHUTDOWN);
	assign go_standby = (state_nxt == ST_STANDBY);
	assign go_acquire = (state_nxt == ST_ACQUIRE);
	assign go_wait_sync = (state_nxt == ST_WAIT_SYNC);
	assign go_latch = (state_nxt == ST_LATCH);
	assign go_line_init = (state_nxt == ST_LINE_INIT);
	assign go_clk_on = (state_nxt == ST_CLK_ON);
	assign go_transmit = (state_nxt == ST_TRANSMIT);
	assign go_pd_clk_off = (state_nxt == ST_PD_CLK_OFF);
	assign go_pd_data_off = (state_nxt == ST_PD_DATA_OFF);
	assign go_locking = go_acquire || go_wait_sync;
	assign go_entry = go_latch || go_line_init || go_clk_on;
	assign go_serial = go_entry || go_transmit || go_pd_clk_off ||
		go_pd_data_off;

	// Outputs decoded from the next state so each flop tracks its state
	assign monitor_enable_nxt = !go_shutdown;
	// PLL stays up through the power-down steps so data ends cleanly
	assign pll_enable_nxt = go_locking || go_serial;
	assign serializer_enable_nxt = go_serial;
	assign shift_load_nxt = go_latch;
	assign line_counter_init_nxt = go_line_init;
	assign line_counter_run_nxt = opt_s2_r &&
		(go_locking || go_entry || go_transmit);
	// Serial clock before data on entry, and off before data on power-down exit
	assign clk_out_oe_nxt = go_clk_on ||
		go_transmit;
	assign data_out_oe_nxt = go_transmit ||
		go_pd_clk_off;
	assign mode_nxt = go_shutdown ? MODE_SHUTDOWN :
		go_standby ? MODE_STANDBY :
		go_locking ? MODE_ACQUIRE : MODE_TRANSMIT;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_r <= ST_SHUTDOWN;
			sync_cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			sync_cnt_r <= sync_cnt_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			monitor_enable_r <= 1'b0;
		end else begin
			monitor_enable_r <= monitor_enable_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pll_enable_r <= 1'b0;
		end else begin
			pll_enable_r <= pll_enable_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			serializer_enable_r <= 1'b0;
		end else begin
			serializer_enable_r <= serializer_enable_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			shift_load_r <= 1'b0;
		end else begin
			shift_load_r <= shift_load_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			line_counter_run_r <= 1'b0;
		end else begin
			line_counter_run_r <= line_counter_run_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			line_counter_init_r <= 1'b0;
		end else begin
			line_counter_init_r <= line_counter_init_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			clk_out_oe_r <= 1'b0;
		end else begin
			clk_out_oe_r <= clk_out_oe_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			data_out_oe_r <= 1'b0;
		end else begin
			data_out_oe_r <= data_out_oe_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mode_r <= MODE_SHUTDOWN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign o_monitor_enable = monitor_enable_r;
	assign o_pll_enable = pll_enable_r;
	assign o_serializer_enable = serializer_enable_r;
	assign o_shift_load = shift_load_r;
	assign o_line_counter_run = line_counter_run_r;
	assign o_line_counter_init = line_counter_init_r;
	assign o_clk_out_oe = clk_out_oe_r;
	assign o_data_out_oe = data_out_oe_r;
	assign o_mode = mode_r;
endmodule
`default_nettype wire

/* shared/pwr_mode_pkg.sv */
// Constants and state type shared by the power-mode controller files
`default_nettype none
package pwr_mode_pkg;
	// Core clock rate and timing figures in their own units
	localparam int CORE_CLK_MHZ = 125;
	localparam int EN_QUAL_NS = 10000;
	localparam int PWRDN_NS = 10000;
	localparam int MON_WIN_NS = 8000;
	// Least times round up to whole core cycles
	localparam logic [10:0] EN_QUAL_CYC =
		11'((EN_QUAL_NS * CORE_CLK_MHZ + 999) / 1000);
	localparam logic [10:0] PWRDN_CYC =
		11'((PWRDN_NS * CORE_CLK_MHZ + 999) / 1000);
	localparam logic [9:0] MON_WIN_CYC =
		10'((MON_WIN_NS * CORE_CLK_MHZ + 999) / 1000);
	// Pixel periods per window: 3 MHz gives 24, 500 kHz gives 4
	localparam logic [7:0] MON_ACT_EDGES = 8'h10;
	localparam logic [7:0] MON_IDLE_EDGES = 8'h08;
	// Frame-sync rising edges awaited after lock
	localparam logic [1:0] SYNC_EDGES_COUNT_OFF = 2'h1;
	localparam logic [1:0] SYNC_EDGES_COUNT_ON = 2'h2;
	// Reset values
	localparam logic QUAL_RESET_LEVEL = 1'b0;
	localparam logic MON_RESET_ACTIVE = 1'b0;
	// Reported mode codes
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h1;
	localparam logic [1:0] MODE_ACQUIRE = 2'h2;
	localparam logic [1:0] MODE_TRANSMIT = 2'h3;

	typedef enum logic [3:0] {
		ST_SHUTDOWN,
		ST_STANDBY,
		ST_ACQUIRE,
		ST_WAIT_SYNC,
		ST_LATCH,
		ST_LINE_INIT,
		ST_CLK_ON,
		ST_TRANSMIT,
		ST_PD_CLK_OFF,
		ST_PD_DATA_OFF
	} mode_state_e;
endpackage
`default_nettype wire

/* tb/pll_lock_model.sv */
// PLL lock model that answers the sequencer's enable
`default_nettype none
module pll_lock_model (
	input wire logic i_core_clk,
	input wire logic i_pll_enable,
	input wire logic i_slow,
	output logic o_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	always @(posedge i_core_clk) begin
		if (!i_pll_enable)
			cnt <= 0;
		else if (cnt < 1000)
			cnt <= cnt + 1;
	end
	// Lock after a short or long wake-up; lost at once when disabled
	assign o_locked = i_pll_enable && cnt >= (i_slow ? 200 : 4);
endmodule
`default_nettype wire

/* tb/serializer_power_mode_control_asserts.sv */
// Port assertions for the power-mode sequencer
`default_nettype none
module serializer_power_mode_control_asserts
	import pwr_mode_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_transmitter_enable_pin,
	input wire logic i_pll_locked,
	input wire logic o_monitor_enable,
	input wire logic o_pll_enable,
	input wire logic o_serializer_enable,
	input wire logic o_shift_load,
	input wire logic o_line_counter_run,
	input wire logic o_line_counter_init,
	input wire logic o_clk_out_oe,
	input wire logic o_data_out_oe,
	input wire logic [1:0] o_mode
);
	logic [10:0] en_hi_r;
	logic [10:0] en_lo_r;
	// Saturating run lengths of the raw enable level
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !i_transmitter_enable_pin)
			en_hi_r <= '0;
		else if (en_hi_r != 11'h7ff)
			en_hi_r <= en_hi_r + 11'h1;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || i_transmitter_enable_pin)
			en_lo_r <= '0;
		else if (en_lo_r != 11'h7ff)
			en_lo_r <= en_lo_r + 11'h1;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	shut_quiet_a: assert property (
		o_mode == MODE_SHUTDOWN |-> !(o_monitor_enable || o_pll_enable
		|| o_clk_out_oe || o_data_out_oe)) else $error("unit on in shutdown");
	standby_quiet_a: assert property (
		o_mode == MODE_STANDBY |-> o_monitor_enable && !o_pll_enable
		&& !o_clk_out_oe && !o_data_out_oe) else $error("standby wrong");
	acquire_hiz_a: assert property (
		o_mode == MODE_ACQUIRE |-> o_pll_enable && !o_clk_out_oe
		&& !o_data_out_oe) else $error("acquire wrong");
	run_needs_pll_a: assert property (
		o_line_counter_run |-> o_pll_enable) else $error("counter without pll");
	wake_qual_a: assert property (
		$rose(o_monitor_enable) |-> o_mode == MODE_STANDBY
		&& en_hi_r >= EN_QUAL_CYC) else $error("early wake");
	sleep_qual_a: assert property (
		$fell(o_monitor_enable) |-> o_mode == MODE_SHUTDOWN
		&& en_lo_r >= PWRDN_CYC) else $error("early shutdown");
	lock_first_a: assert property (
		$rose(o_shift_load) |-> $past(i_pll_locked, 3)
		&& o_serializer_enable) else $error("latch before lock");
	init_order_a: assert property (
		$rose(o_line_counter_init) |-> $past(o_shift_load))
		else $error("init before latch");
	clk_order_a: assert property (
		$rose(o_clk_out_oe) |-> $past(o_line_counter_init) && !o_data_out_oe)
		else $error("clock on out of order");
	data_order_a: assert property (
		$rose(o_data_out_oe) |-> $past(o_clk_out_oe)) else $error("data early");
	pd_order_a: assert property (
		$fell(o_clk_out_oe) && o_data_out_oe |=> !o_data_out_oe)
		else $error("data kept after clock off");
	loss_standby_a: assert property (
		$fell(o_pll_enable) && o_monitor_enable |-> o_mode == MODE_STANDBY)
		else $error("clock loss not standby");
	cover property ($rose(o_data_out_oe));
	cover property ($fell(o_pll_enable) && o_monitor_enable);
	cover property ($rose(o_shift_load) && o_line_counter_run);
endmodule
bind serializer_power_mode_control serializer_power_mode_control_asserts
	u_serializer_power_mode_control_asserts (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_transmitter_enable_pin(i_transmitter_enable_pin),
	.i_pll_locked(i_pll_locked), .o_monitor_enable(o_monitor_enable),
	.o_pll_enable(o_pll_enable), .o_serializer_enable(o_serializer_enable),
	.o_shift_load(o_shift_load), .o_line_counter_run(o_line_counter_run),
	.o_line_counter_init(o_line_counter_init), .o_clk_out_oe(o_clk_out_oe),
	.o_data_out_oe(o_data_out_oe), .o_mode(o_mode));
`default_nettype wire

/* tb/serializer_power_mode_control_tb_top.sv */
// Bench for the power-mode sequencer: wake, transmit, clock loss, power-down
`default_nettype none
module serializer_power_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pwr_mode_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic pclk = 1'b0;
	logic pclk_run = 1'b0;
	logic en = 1'b0;
	logic opt = 1'b0;
	logic fs = 1'b0;
	logic slow = 1'b0;
	logic lock;
	logic mon, pll, ser, ld, run, init, coe, doe;
	logic [1:0] mode;
	int err_total = 0;
	int samples_checked = 0;
	always #4 i_core_clk = ~i_core_clk;
	// Pixel clock stands still while pclk_run is low; offset keeps it off core edges
	initial begin
		#3;
		forever #16 pclk = pclk_run ? ~pclk : 1'b0;
	end
	serializer_power_mode_control u_serializer_power_mode_control (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_pixel_clock_input(pclk),
		.i_transmitter_enable_pin(en), .i_line_count_option(opt),
		.i_frame_sync(fs), .i_pll_locked(lock), .o_monitor_enable(mon),
		.o_pll_enable(pll), .o_serializer_enable(ser), .o_shift_load(ld),
		.o_line_counter_run(run), .o_line_counter_init(init),
		.o_clk_out_oe(coe), .o_data_out_oe(doe), .o_mode(mode));
	pll_lock_model u_pll_lock_model (.i_core_clk(i_core_clk),
		.i_pll_enable(pll), .i_slow(slow), .o_locked(lock));
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [4:0] seen, input logic [4:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim, output int n);
		n = 0;
		while (mode !== m) begin
			@(negedge i_core_clk);
			n++;
			if (n > lim) begin
				err_total++;
				$display("[ERR] %0t mode %0d never came", $time, m);
				final_report();
			end
		end
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge i_core_clk);
	endtask
	task automatic sync_pulse();
		fs = 1'b1;
		cycles(4);
		fs = 1'b0;
		cycles(4);
	endtask
	task automatic t_short_en();
		en = 1'b1;
		cycles(1000);
		en = 1'b0;
		cycles(1600);
		check(mode, MODE_SHUTDOWN, "short enable");
		$display("test short enable done");
	endtask
	task automatic t_wake();
		int n;
		en = 1'b1;
		wait_mode(MODE_STANDBY, 1400, n);
		check(n >= EN_QUAL_CYC, 1'b1, "wake too soon");
		check({mon, pll, coe, doe}, 4'h8, "standby units");
		$display("test wake done");
	endtask
	task automatic t_transmit(input logic o, input logic s);
		int n;
		opt = o;
		slow = s;
		pclk_run = 1'b1;
		// First monitor window after the clock starts may be spoilt
		wait_mode(MODE_ACQUIRE, 3200, n);
		check({pll, coe, doe}, 3'h4, "acquire");
		check(run, o, "line counter run");
		if (s)
			sync_pulse();
		cycles(210);
		check(mode, MODE_ACQUIRE, "sync before lock");
		if (o) begin
			sync_pulse();
			cycles(20);
			check(mode, MODE_ACQUIRE, "one sync with option");
		end
		fs = 1'b1;
		wait_mode(MODE_TRANSMIT, 20, n);
		check({ser, ld, init, coe}, 4'hc, "latch step");
		cycles(1);
		check({ld, init, coe}, 3'h2, "init step");
		cycles(1);
		check({init, coe, doe}, 3'h2, "clock step");
		cycles(1);
		check({ser, coe, doe}, 3'h7, "data step");
		fs = 1'b0;
		$display("test transmit done");
	endtask
	task automatic t_loss();
		int n;
		// Option moves only while active, never in standby
		opt = 1'b1;
		pclk_run = 1'b0;
		wait_mode(MODE_STANDBY, 2500, n);
		check({mon, pll, ser, coe, doe}, 5'h10, "clock lost");
		$display("test clock loss done");
	endtask
	task automatic t_down();
		int n;
		en = 1'b0;
		wait_mode(MODE_SHUTDOWN, 1400, n);
		check(n >= PWRDN_CYC, 1'b1, "power-down too soon");
		check({mon, pll, ser, coe, doe}, 5'h0, "shutdown units");
		// Inputs held static while asleep to keep leakage down
		pclk_run = 1'b0;
		$display("test power-down done");
	endtask
	initial begin
		cycles(10);
		i_rst_n = 1'b1;
		cycles(1);
		check({mode, coe, doe}, 4'h0, "after reset");
		t_short_en();
		t_wake();
		t_transmit(1'b0, 1'b0);
		t_loss();
		t_transmit(1'b1, 1'b1);
		t_down();
		final_report();
	end
endmodule
`default_nettype wire
